// ### alc_ddg_map.svh
// Address map, field positions, reset values and timing constants of the level control block.
`ifndef ALC_DDG_MAP_SVH
`define ALC_DDG_MAP_SVH

// Register indices; the byte address of each is four times its index.
`define ALC_IDX_DECAY 8'h5A
`define ALC_IDX_NOISE 8'h5B
`define ALC_IDX_SIGNAL 8'h5C
`define ALC_IDX_GAIN 8'h5D
`define ALC_IDX_SHIFT 2

// Field positions inside the decay register.
`define ALC_DECAY_TIME_HI 7
`define ALC_DECAY_TIME_LO 3
`define ALC_DECAY_SCALE_HI 2
`define ALC_DECAY_SCALE_LO 0

// Top bit positions of the debounce register fields.
`define ALC_NOISE_HI 4
`define ALC_SIGNAL_HI 3

// Reset values of the fields and of the gain status.
`define ALC_RST_DECAY_TIME 5'h00
`define ALC_RST_DECAY_SCALE 3'h0
`define ALC_RST_NOISE 5'h00
`define ALC_RST_SIGNAL 4'h0
`define ALC_RST_GAIN 8'h00

// Timing constants, counted in ADC word clocks.
`define ALC_DECAY_UNIT_SHIFT 9
`define ALC_EXP_BREAK 5'h04
`define ALC_NOISE_LIN_FIRST 5'h0C
`define ALC_NOISE_LIN_BASE 5'h0A
`define ALC_NOISE_LIN_MAX 5'h14
`define ALC_NOISE_LIN_UNIT 17'h01000
`define ALC_SIGNAL_LIN_FIRST 4'hB
`define ALC_SIGNAL_LIN_BASE 4'h9
`define ALC_SIGNAL_LIN_UNIT 14'h0800

// Applied gain limits in half decibel steps.
`define ALC_GAIN_MIN 8'hE8
`define ALC_GAIN_MAX 8'h74

// Bus responses.
`define ALC_RESP_OKAY 2'h0
`define ALC_RESP_SLVERR 2'h2

`endif

// ### alc_ddg_pkg.sv
// Types shared by the level control decay, debounce and gain status block.
package alc_ddg_pkg;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    ALC_SEL_DECAY = 3'h0,
    ALC_SEL_NOISE = 3'h1,
    ALC_SEL_SIGNAL = 3'h2,
    ALC_SEL_GAIN = 3'h3,
    ALC_SEL_NONE = 3'h4
  } alc_sel_t;

endpackage : alc_ddg_pkg

// ### alc_ddg.sv
// Decay time, debounce times and applied gain status of the left level control channel.
//
// The AXI4-Lite register port is this design's own decision.
`include "alc_ddg_map.svh"

// Notes on behaviour
// RQ1 - Decay time is (2N+1) times 512.
// RQ2 - Decay scale multiplies by two to N.
// RQ3 - Noise debounce code one zero, then doubling.
// RQ4 - Upper noise codes linear in 4096, capped twenty.
// RQ5 - Signal debounce code one zero, then doubling.
// RQ6 - Upper signal codes linear in 2048 steps.
// RQ7 - Applied gain read back as signed halfdB.
// RQ8 - Reserved bits read zero; software writes zero.
// RQ9 - Reset clears timings and gain status.
// RQ10 - Zero noise threshold disables noise debounce.
// RQ11 - Zero debounce code means no delay.
module alc_ddg
  import alc_ddg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  // Write address channel.
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Gain the level control loop applies now, same clock domain.
  input wire logic [7:0] appliedGain,
  // Noise threshold field of the neighbouring control register.
  input wire logic [4:0] noiseThreshold,
  // Decay interval in ADC word clocks.
  output logic [21:0] decayWordClocks,
  // Noise debounce interval in ADC word clocks.
  output logic [16:0] noiseDebounceWordClocks,
  // Signal debounce interval in ADC word clocks.
  output logic [13:0] signalDebounceWordClocks,
  // High while the noise gate is in use.
  output logic noiseGateEnable
);

  // Maps a byte address onto a register; misaligned or foreign words select none.
  function automatic alc_sel_t decodeAddr(input logic [31:0] addr);
    alc_sel_t sel;
    sel = ALC_SEL_NONE;
    if (addr[1:0] == 2'h0 && addr[31:10] == 22'h000000) begin
      unique case (addr[9:`ALC_IDX_SHIFT])
        `ALC_IDX_DECAY: sel = ALC_SEL_DECAY;
        `ALC_IDX_NOISE: sel = ALC_SEL_NOISE;
        `ALC_IDX_SIGNAL: sel = ALC_SEL_SIGNAL;
        `ALC_IDX_GAIN: sel = ALC_SEL_GAIN;
        default: sel = ALC_SEL_NONE;
      endcase
    end
    return sel;
  endfunction : decodeAddr

  // Doubling part of both debounce tables: codes 0 and 1 give no delay,
  // codes 2 and 3 give 4 and 8, and from code 4 on the value is two to code plus one.
  function automatic logic [16:0] expTime(input logic [4:0] code);
    logic [16:0] t;
    t = 17'h00000;
    if (code >= `ALC_EXP_BREAK) begin
      t = 17'h00001 << (code + 5'h01);
    end else if (code > 5'h01) begin
      t = 17'h00001 << code;
    end
    return t;
  endfunction : expTime

  // Stored control fields; reserved bits are not stored at all.
  logic [4:0] decayTime_q;
  logic [2:0] decayScale_q;
  logic [4:0] noiseCode_q;
  logic [3:0] signalCode_q;
  logic [7:0] gainStatus_q;

  // Write path state: captured address and data, each held until the response.
  logic awHeld_q;
  logic wHeld_q;
  logic [31:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  // Ready flags are flops of their own so the bus sees them straight from a register.
  logic awReady_q;
  logic wReady_q;

  // Read path state.
  logic rValid_q;
  logic [1:0] rResp_q;
  logic [31:0] rData_q;
  // Read address ready, high whenever no read answer is standing.
  logic arReady_q;

  // Computed intervals and gate state.
  logic [21:0] decay_q;
  logic [16:0] noiseDeb_q;
  logic [13:0] signalDeb_q;
  logic gateOn_q;

  // Combinational helpers.
  logic writeFire;
  alc_sel_t wSel;
  alc_sel_t rSel;
  logic [21:0] decay_d;
  logic [16:0] noise_d;
  logic [13:0] signal_d;
  logic [7:0] gain_d;

  // A write completes once both address and data are held and no response is pending.
  assign writeFire = awHeld_q && wHeld_q && !bValid_q;
  assign wSel = decodeAddr(awAddr_q);
  assign rSel = decodeAddr(s_axi_araddr);

  // Address is accepted whenever none is held.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      awReady_q <= 1'b1;
      awAddr_q <= 32'h00000000;
    end else if (s_axi_awvalid && !awHeld_q) begin
      awHeld_q <= 1'b1;
      awReady_q <= 1'b0;
      awAddr_q <= s_axi_awaddr;
    end else if (writeFire) begin
      awHeld_q <= 1'b0;
      awReady_q <= 1'b1;
    end
  end

  // Data is accepted whenever none is held, independent of the address.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wHeld_q <= 1'b0;
      wReady_q <= 1'b1;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else if (s_axi_wvalid && !wHeld_q) begin
      wHeld_q <= 1'b1;
      wReady_q <= 1'b0;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end else if (writeFire) begin
      wHeld_q <= 1'b0;
      wReady_q <= 1'b1;
    end
  end

  // Write response follows the completed write and stands until taken.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bValid_q <= 1'b0;
      bResp_q <= `ALC_RESP_OKAY;
    end else if (writeFire) begin
      bValid_q <= 1'b1;
      // Unmapped words answer with a slave error; the gain word ignores writes.
      bResp_q <= (wSel == ALC_SEL_NONE) ? `ALC_RESP_SLVERR : `ALC_RESP_OKAY;
    end else if (s_axi_bready) begin
      bValid_q <= 1'b0;
    end
  end

  // Control fields; only byte lane 0 carries them and reserved bits are dropped.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      decayTime_q <= `ALC_RST_DECAY_TIME; // [RQ9]
      decayScale_q <= `ALC_RST_DECAY_SCALE; // [RQ9]
      noiseCode_q <= `ALC_RST_NOISE; // [RQ9]
      signalCode_q <= `ALC_RST_SIGNAL; // [RQ9]
    end else if (writeFire && wStrb_q[0]) begin
      unique case (wSel)
        ALC_SEL_DECAY: begin
          decayTime_q <= wData_q[`ALC_DECAY_TIME_HI:`ALC_DECAY_TIME_LO]; // [RQ1]
          decayScale_q <= wData_q[`ALC_DECAY_SCALE_HI:`ALC_DECAY_SCALE_LO]; // [RQ2]
        end
        ALC_SEL_NOISE: begin
          noiseCode_q <= wData_q[`ALC_NOISE_HI:0]; // [RQ8]
        end
        ALC_SEL_SIGNAL: begin
          signalCode_q <= wData_q[`ALC_SIGNAL_HI:0]; // [RQ8]
        end
        ALC_SEL_GAIN: begin
          // Read-only word: writes leave everything as it was.
        end
        ALC_SEL_NONE: begin
          // Nothing is stored for an unmapped word.
        end
      endcase
    end
  end

  // Read path: one read at a time, data presented the cycle after the address.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rValid_q <= 1'b0;
      arReady_q <= 1'b1;
      rResp_q <= `ALC_RESP_OKAY;
      rData_q <= 32'h00000000;
    end else if (s_axi_arvalid && !rValid_q) begin
      rValid_q <= 1'b1;
      arReady_q <= 1'b0;
      rResp_q <= `ALC_RESP_OKAY;
      rData_q <= 32'h00000000;
      // Every unused and reserved bit reads as zero.
      unique case (rSel)
        ALC_SEL_DECAY: begin
          rData_q[`ALC_DECAY_TIME_HI:`ALC_DECAY_TIME_LO] <= decayTime_q;
          rData_q[`ALC_DECAY_SCALE_HI:`ALC_DECAY_SCALE_LO] <= decayScale_q;
        end
        ALC_SEL_NOISE: begin
          rData_q[`ALC_NOISE_HI:0] <= noiseCode_q; // [RQ8]
        end
        ALC_SEL_SIGNAL: begin
          rData_q[`ALC_SIGNAL_HI:0] <= signalCode_q; // [RQ8]
        end
        ALC_SEL_GAIN: begin
          rData_q[7:0] <= gainStatus_q; // [RQ7]
        end
        ALC_SEL_NONE: begin
          rResp_q <= `ALC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rValid_q <= 1'b0;
      arReady_q <= 1'b1;
    end
  end

  // Decay: odd multiple of 512, then shifted by the scale code.
  always_comb begin
    decay_d = 22'({16'h0000, decayTime_q, 1'b1} << `ALC_DECAY_UNIT_SHIFT); // [RQ1]
    decay_d = decay_d << decayScale_q; // [RQ2]
  end

  // Noise debounce: doubling codes, then linear steps of 4096 capped at twenty.
  always_comb begin
    noise_d = expTime(noiseCode_q); // [RQ3] [RQ11]
    if (noiseCode_q >= `ALC_NOISE_LIN_FIRST) begin
      if (noiseCode_q - `ALC_NOISE_LIN_BASE >= `ALC_NOISE_LIN_MAX) begin
        noise_d = 17'(`ALC_NOISE_LIN_MAX * `ALC_NOISE_LIN_UNIT); // [RQ4]
      end else begin
        noise_d = 17'((noiseCode_q - `ALC_NOISE_LIN_BASE) * `ALC_NOISE_LIN_UNIT); // [RQ4]
      end
    end
    // With the gate off the debounce has no effect.
    if (noiseThreshold == 5'h00) begin
      noise_d = 17'h00000; // [RQ10]
    end
  end

  // Signal debounce: doubling codes, then linear steps of 2048.
  always_comb begin
    signal_d = 14'(expTime({1'b0, signalCode_q})); // [RQ5] [RQ11]
    if (signalCode_q >= `ALC_SIGNAL_LIN_FIRST) begin
      signal_d = 14'((signalCode_q - `ALC_SIGNAL_LIN_BASE) * `ALC_SIGNAL_LIN_UNIT); // [RQ6]
    end
  end

  // Applied gain is held inside its documented signed range.
  always_comb begin
    gain_d = appliedGain;
    if ($signed(appliedGain) < $signed(`ALC_GAIN_MIN)) begin
      gain_d = `ALC_GAIN_MIN; // [RQ7]
    end else if ($signed(appliedGain) > $signed(`ALC_GAIN_MAX)) begin
      gain_d = `ALC_GAIN_MAX; // [RQ7]
    end
  end

  // Gain status register follows the loop every cycle.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gainStatus_q <= `ALC_RST_GAIN; // [RQ9]
    end else begin
      gainStatus_q <= gain_d; // [RQ7]
    end
  end

  // Registered intervals and gate state for the level control loop.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      decay_q <= 22'h000000;
      noiseDeb_q <= 17'h00000;
      signalDeb_q <= 14'h0000;
      gateOn_q <= 1'b0;
    end else begin
      decay_q <= decay_d;
      noiseDeb_q <= noise_d;
      signalDeb_q <= signal_d;
      gateOn_q <= (noiseThreshold != 5'h00); // [RQ10]
    end
  end

  // Outputs come straight from the flip-flops above.
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rresp = rResp_q;
  assign s_axi_rdata = rData_q;
  assign decayWordClocks = decay_q;
  assign noiseDebounceWordClocks = noiseDeb_q;
  assign signalDebounceWordClocks = signalDeb_q;
  assign noiseGateEnable = gateOn_q;

endmodule : alc_ddg

// ### alc_ddg_chk.sv
// Checker of bus handshakes and decoded intervals of the level control block.
module alc_ddg_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] noiseThreshold,
  input wire logic [21:0] decayWordClocks,
  input wire logic [16:0] noiseDebounceWordClocks,
  input wire logic [13:0] signalDebounceWordClocks,
  input wire logic noiseGateEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A read answer shows one edge after its address, a write answer one edge after the
  // held address and data meet; both stay until taken.
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early.");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early.");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer missing.");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> ##1 s_axi_bvalid) else $error("Write answer missing.");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero.");
  // Decoded intervals keep the shape the timing codes allow.
  decay_form_a: assert property ($past(rst_n) |-> decayWordClocks[8:0] == 9'h000
    && decayWordClocks != 22'h000000) else $error("Decay interval malformed.");
  noise_cap_a: assert property (noiseDebounceWordClocks <= 17'h14000)
    else $error("Noise debounce above cap.");
  sig_cap_a: assert property (signalDebounceWordClocks <= 14'h3000)
    else $error("Signal debounce above cap.");
  gate_en_a: assert property ($past(rst_n) |->
    noiseGateEnable == ($past(noiseThreshold) != 5'h00)) else $error("Gate enable wrong.");
  gate_off_a: assert property ((noiseThreshold == 5'h00)[*2] |=>
    noiseDebounceWordClocks == 17'h00000) else $error("Noise debounce with gate off.");
endmodule : alc_ddg_chk

bind alc_ddg alc_ddg_chk i_alc_ddg_chk (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .noiseThreshold,
  .decayWordClocks, .noiseDebounceWordClocks, .signalDebounceWordClocks, .noiseGateEnable);

// ### alc_ddg_test.sv
// Self-checking bench of the level control decay, debounce and gain status block.
module alc_ddg_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, noiseGateEnable;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] appliedGain = 8'h00;
  logic [4:0] noiseThreshold = 5'h01;
  logic [21:0] decayWordClocks;
  logic [16:0] noiseDebounceWordClocks;
  logic [13:0] signalDebounceWordClocks;
  int n_errors = 0, n_checks = 0;
  // The clock toggles every half period of 2 ns.
  always #2 clock = ~clock;
  alc_ddg i_alc_ddg (.clock, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .appliedGain,
    .noiseThreshold, .decayWordClocks, .noiseDebounceWordClocks, .signalDebounceWordClocks,
    .noiseGateEnable);
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Compares a seen value with the model's value.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write of one word; waits for the response under a bound.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    if (n == 50) begin
      n_errors++;
      summarize();
    end else begin
      chk(s_axi_bresp, er);
      s_axi_bready <= 0;
      @(posedge clock);
    end
  endtask : wr
  // Read of one word, compared with the model.
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    if (n == 50) begin
      n_errors++;
      summarize();
    end else begin
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 0;
      @(posedge clock);
    end
  endtask : rd
  // Model of the debounce tables: doubling codes, then linear steps.
  function automatic int dbM(int c, int top, int unit, int base);
    if (c < 2) return 0;
    if (c < 4) return 1 << c;
    if (c < top) return 1 << (c + 1);
    return (c - base) * unit;
  endfunction : dbM
  // Model of the gain status clamp.
  function automatic logic [7:0] gainM(logic [7:0] g);
    if ($signed(g) < -24) return 8'hE8;
    if ($signed(g) > 116) return 8'h74;
    return g;
  endfunction : gainM
  initial begin
    void'($urandom(46083));
    repeat (6) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    for (int i = 0; i < 4; i++) rd(32'h168 + 4 * i, 0, 0);
    chk(decayWordClocks, 512);
    chk(noiseDebounceWordClocks + signalDebounceWordClocks, 0);
    $display("Test reset done");
    for (int i = 0; i < 16; i++) begin
      v = (i == 15) ? 32'hFF : ($urandom & 32'hF8) | (i & 7);
      wr(32'h168, v, 4'hF, 0);
      rd(32'h168, v, 0);
      chk(decayWordClocks, ((v >> 3) * 2 + 1) * 512 << (v & 7));
    end
    $display("Test decay done");
    for (int c = 0; c < 32; c++) begin
      noiseThreshold <= 5'($urandom_range(31, 1));
      wr(32'h16C, c, 4'hF, 0);
      rd(32'h16C, c, 0);
      chk(noiseDebounceWordClocks, dbM(c > 30 ? 30 : c, 12, 4096, 10));
      chk(noiseGateEnable, 1);
    end
    noiseThreshold <= 0;
    repeat (3) @(posedge clock);
    chk({noiseGateEnable, noiseDebounceWordClocks}, 0);
    for (int c = 0; c < 16; c++) begin
      wr(32'h170, c, 4'hF, 0);
      rd(32'h170, c, 0);
      chk(signalDebounceWordClocks, dbM(c, 11, 2048, 9));
    end
    $display("Test debounce done");
    for (int i = 0; i < 9; i++) begin
      appliedGain <= (i < 8) ? 8'(64'hE8E7807475007F01 >> (8 * i)) : 8'($urandom);
      repeat (2) @(posedge clock);
      rd(32'h174, gainM(appliedGain), 0);
    end
    wr(32'h174, 32'h5, 4'hF, 0);
    rd(32'h174, gainM(appliedGain), 0);
    $display("Test gain done");
    wr(32'h170, 32'h3, 4'h0, 0);
    rd(32'h170, 32'hF, 0);
    wr(32'h178, 32'h1, 4'hF, 2);
    rd(32'h178, 0, 2);
    rd(32'h169, 0, 2);
    rst_n <= 0;
    @(posedge clock);
    rst_n <= 1;
    rd(32'h170, 0, 0);
    $display("Test errors and reset done");
    summarize();
  end
endmodule : alc_ddg_test
